// ===== rtl/isl_fifo.sv
`timescale 1ns/1ps
module isl_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Streams
    isl_stream_if.snk wr,
    isl_stream_if.src rd
);
    localparam int AW = $clog2(D);

    logic [W-1:0]  mem [D];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0]   cnt_r;
    logic          push;
    logic          pop;

    assign wr.ready = (cnt_r != (AW+1)'(D));
    assign rd.valid = (cnt_r != '0);
    assign rd.data  = mem[rp_r];
    assign push     = wr.valid && wr.ready;
    assign pop      = rd.valid && rd.ready;

    always_ff @(posedge core_clk)
    begin
        if (push)
        begin
            mem[wp_r] <= wr.data;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end
        else
        begin
            if (push)
            begin
                wp_r <= (wp_r == AW'(D - 1)) ? '0 : wp_r + AW'(1);
            end
            if (pop)
            begin
                rp_r <= (rp_r == AW'(D - 1)) ? '0 : rp_r + AW'(1);
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    chk_fifo_no_overfill : assert property (@(posedge core_clk) disable iff (!resetn)
        (cnt_r == (AW+1)'(D)) && !pop |=> (cnt_r == (AW+1)'(D)) && !wr.ready)
        else $error("fifo count moved past full");
endmodule : isl_fifo

// ===== rtl/isl_pkg.sv
package isl_pkg;
    // Clocking and power-up timing
    localparam longint CLK_HZ       = 64'd20_000_000;
    localparam longint AFS_DELAY_US = 64'd100;
    localparam longint US_PER_S     = 64'd1_000_000;
    localparam int     AFS_CYC      = int'((AFS_DELAY_US * CLK_HZ + US_PER_S - 1) / US_PER_S);
    localparam int     AFS_CNT_W    = 12;

    // Data path
    localparam int DATA_W    = 8;
    localparam int FIFO_D    = 8;
    localparam int BIT_CNT_W = 3;
    localparam logic [BIT_CNT_W-1:0] LAST_BIT = 3'h7;

    // Synchronised pin bundle layout
    localparam int PIN_W   = 13;
    localparam int P_CS    = 0;
    localparam int P_LAT   = 1;
    localparam int P_SERIAL_OUT_ENABLE_N = 2;
    localparam int P_RDY   = 3;
    localparam int P_FLT   = 4;
    localparam int P_IN    = 5;
    // Idle levels of undriven pins: selects high, ready high, inputs low
    localparam logic [PIN_W-1:0] PIN_IDLE = 13'h001F;

    typedef enum logic [2:0] {
        ISL_OFF  = 3'b001,
        ISL_WAIT = 3'b010,
        ISL_ON   = 3'b100
    } isl_pwr_t;

    // Output driven unless select and enable are both high
    function automatic logic isl_sdo_on(input logic cs_n, input logic en_n);
        isl_sdo_on = !(cs_n && en_n);
    endfunction : isl_sdo_on
endpackage : isl_pkg

// ===== rtl/isl_port.sv
// Notes on behaviour
// - Host select low enables serial output and drives field select low.
// - Host serial input sampled on each rising serial clock edge.
// - Serial output floats only while select and output enable both high.
// - Serial output changes on falling serial clock edges and clears to low when select rises.
// - Host latch strobe low drives field latch low, capturing eight inputs.
// - Open-drain fault line pulled low while a field fault exists.
// - Field-active high only while field runs normally and ready is low.
// - Unpowered field: active low, fault low, serial output low when enabled.
// - Nominal delay after field power before field-active rises.
// - Field select low keeps inputs latched and field serial port active.
// - Undriven select, latch, enable idle high; clock and data idle low.
// - Serial clock and select reproduced as field-side outputs.
// - Input latch transparent while field select and latch high.
`timescale 1ns/1ps
module isl_port
    import isl_pkg::*;
(
    // Core clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 resetn,
    // Host serial pins
    input  wire logic                 host_serial_clock,
    input  wire logic                 host_chip_select_n,
    input  wire logic                 host_serial_in,
    input  wire logic                 host_latch_strobe_n,
    input  wire logic                 serial_out_enable_n,
    output logic                      host_serial_out,
    output logic                      host_serial_out_oe,
    // Host fault, open drain
    output logic                      host_fault_n_out,
    output logic                      host_fault_n_oe,
    output logic                      field_side_active,
    // Field-side pins
    output logic                      field_chip_select_n,
    output logic                      field_serial_clock,
    output logic                      field_latch_n,
    output logic                      isolated_serial_in_copy,
    input  wire logic                 field_serial_in,
    input  wire logic                 field_ready_in_n,
    input  wire logic                 field_fault_in_n,
    input  wire logic [isl_pkg::DATA_W-1:0] field_inputs,
    // Received host bytes
    output logic [isl_pkg::DATA_W-1:0] rx_data,
    output logic                      rx_valid,
    input  wire logic                 rx_ready
);
    import isl_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_s1_r;
    logic [PIN_W-1:0] pin_s2_r;

    assign pin_raw = {field_inputs, field_fault_in_n, field_ready_in_n,
                      serial_out_enable_n, host_latch_strobe_n, host_chip_select_n};

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            pin_s1_r <= PIN_IDLE;
            pin_s2_r <= PIN_IDLE;
        end
        else
        begin
            pin_s1_r <= pin_raw;
            pin_s2_r <= pin_s1_r;
        end
    end

    // ------------------------------------------------------------
    // Field power-up sequencing
    // ------------------------------------------------------------
    isl_pwr_t             pwr_r;
    isl_pwr_t             pwr_nxt;
    logic [AFS_CNT_W-1:0] dly_r;
    logic                 act_r;
    logic                 fault_oe_r;

    always_comb
    begin
        pwr_nxt = pwr_r;
        case (pwr_r)
            ISL_OFF:
            begin
                if (!pin_s2_r[P_RDY])
                begin
                    pwr_nxt = ISL_WAIT;
                end
            end
            ISL_WAIT:
            begin
                if (pin_s2_r[P_RDY])
                begin
                    pwr_nxt = ISL_OFF;
                end
                else if (dly_r == AFS_CNT_W'(AFS_CYC - 1))
                begin
                    pwr_nxt = ISL_ON;
                end
            end
            ISL_ON:
            begin
                if (pin_s2_r[P_RDY])
                begin
                    pwr_nxt = ISL_OFF;
                end
            end
            default:
            begin
                pwr_nxt = ISL_OFF;
            end
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn || pwr_r != ISL_WAIT)
        begin
            dly_r <= '0;
        end
        else
        begin
            dly_r <= dly_r + AFS_CNT_W'(1);
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            pwr_r <= ISL_OFF;
            act_r <= 1'b0;
        end
        else
        begin
            pwr_r <= pwr_nxt;
            act_r <= (pwr_nxt == ISL_ON);
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            fault_oe_r <= 1'b1;
        end
        else
        begin
            fault_oe_r <= (pwr_nxt != ISL_ON) || !pin_s2_r[P_FLT];
        end
    end

    // ------------------------------------------------------------
    // Field select, latch and input capture
    // ------------------------------------------------------------
    logic              fcs_r;
    logic              flat_r;
    logic              sdo_oe_r;
    logic [DATA_W-1:0] snap_r;
    logic              snap_act_r;

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            fcs_r    <= 1'b1;
            flat_r   <= 1'b1;
            sdo_oe_r <= 1'b0;
        end
        else
        begin
            fcs_r    <= pin_s2_r[P_CS];
            flat_r   <= pin_s2_r[P_LAT];
            sdo_oe_r <= isl_sdo_on(pin_s2_r[P_CS], pin_s2_r[P_SERIAL_OUT_ENABLE_N]);
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            snap_r     <= '0;
            snap_act_r <= 1'b0;
        end
        else if (fcs_r && flat_r)
        begin
            snap_r     <= pin_s2_r[P_IN +: DATA_W];
            snap_act_r <= act_r;
        end
    end

    // ------------------------------------------------------------
    // Link domain on the host serial clock
    // ------------------------------------------------------------
    // Clock may stand still between frames; counters clear on select high
    logic                 lrst_n_r;
    logic                 frame_clr;
    logic [BIT_CNT_W-1:0] rx_cnt_r;
    logic [DATA_W-1:0]    rx_sh_r;
    logic [DATA_W-1:0]    rx_word_r;
    logic                 rx_tgl_r;
    logic                 sdi_copy_r;
    logic                 fsi_r;
    logic                 tx_first_r;
    logic [DATA_W-1:0]    tx_sh_r;
    logic                 sdo_r;

    always_ff @(posedge core_clk)
    begin
        lrst_n_r <= resetn;
    end

    assign frame_clr = host_chip_select_n || !lrst_n_r;

    always_ff @(posedge host_serial_clock or posedge frame_clr)
    begin
        if (frame_clr)
        begin
            rx_cnt_r <= '0;
        end
        else
        begin
            rx_cnt_r <= rx_cnt_r + BIT_CNT_W'(1);
        end
    end

    always_ff @(posedge host_serial_clock or negedge lrst_n_r)
    begin
        if (!lrst_n_r)
        begin
            rx_sh_r    <= '0;
            rx_word_r  <= '0;
            rx_tgl_r   <= 1'b0;
            sdi_copy_r <= 1'b0;
            fsi_r      <= 1'b0;
        end
        else
        begin
            rx_sh_r    <= {rx_sh_r[DATA_W-2:0], host_serial_in};
            sdi_copy_r <= host_serial_in;
            fsi_r      <= field_serial_in;
            if (rx_cnt_r == LAST_BIT && !host_chip_select_n)
            begin
                rx_word_r <= {rx_sh_r[DATA_W-2:0], host_serial_in};
                rx_tgl_r  <= !rx_tgl_r;
            end
        end
    end

    // Snapshot is frozen since select fell, so link reads it as static
    // falling-edge update
    always_ff @(negedge host_serial_clock or posedge frame_clr)
    begin
        if (frame_clr)
        begin
            tx_first_r <= 1'b1;
            tx_sh_r    <= '0;
            sdo_r      <= 1'b0;
        end
        else if (tx_first_r)
        begin
            tx_first_r <= 1'b0;
            tx_sh_r    <= {snap_r[DATA_W-2:0], fsi_r};
            sdo_r      <= snap_act_r && snap_r[DATA_W-1];
        end
        else
        begin
            tx_sh_r <= {tx_sh_r[DATA_W-2:0], fsi_r};
            sdo_r   <= snap_act_r && tx_sh_r[DATA_W-1];
        end
    end

    // ------------------------------------------------------------
    // Byte crossing into the core domain
    // ------------------------------------------------------------
    logic              tgl_s1_r;
    logic              tgl_s2_r;
    logic              tgl_seen_r;
    logic              pend_v_r;
    logic [DATA_W-1:0] pend_d_r;
    logic [DATA_W-1:0] rxd_r;
    logic              rxv_r;

    isl_stream_if #(.W(DATA_W)) f_in ();
    isl_stream_if #(.W(DATA_W)) f_out ();

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            tgl_s1_r   <= 1'b0;
            tgl_s2_r   <= 1'b0;
            tgl_seen_r <= 1'b0;
        end
        else
        begin
            tgl_s1_r   <= rx_tgl_r;
            tgl_s2_r   <= tgl_s1_r;
            tgl_seen_r <= tgl_s2_r;
        end
    end

    // Word is stable for eight link edges after the toggle, ample to copy
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            pend_v_r <= 1'b0;
            pend_d_r <= '0;
        end
        else if (tgl_s2_r != tgl_seen_r)
        begin
            pend_v_r <= 1'b1;
            pend_d_r <= rx_word_r;
        end
        else if (f_in.ready)
        begin
            pend_v_r <= 1'b0;
        end
    end

    assign f_in.valid  = pend_v_r;
    assign f_in.data   = pend_d_r;
    assign f_out.ready = !rxv_r || rx_ready;

    isl_fifo #(
        .W (DATA_W),
        .D (FIFO_D)
    ) u_fifo (
        .core_clk (core_clk),
        .resetn   (resetn),
        .wr       (f_in.snk),
        .rd       (f_out.src)
    );

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            rxv_r <= 1'b0;
            rxd_r <= '0;
        end
        else if (f_out.ready)
        begin
            rxv_r <= f_out.valid;
            rxd_r <= f_out.data;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // clock repeated as a buffer; a flop would halve its rate
    assign field_serial_clock      = host_serial_clock;
    assign field_chip_select_n     = fcs_r;
    assign field_latch_n           = flat_r;
    assign isolated_serial_in_copy = sdi_copy_r;
    assign host_serial_out         = sdo_r;
    assign host_serial_out_oe      = sdo_oe_r;
    assign host_fault_n_out        = 1'b0;
    assign host_fault_n_oe         = fault_oe_r;
    assign field_side_active       = act_r;
    assign rx_data                 = rxd_r;
    assign rx_valid                = rxv_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [AFS_CNT_W-1:0] rdy_lo_r;

    always_ff @(posedge core_clk)
    begin
        if (!resetn || pin_s2_r[P_RDY])
        begin
            rdy_lo_r <= '0;
        end
        else if (rdy_lo_r != '1)
        begin
            rdy_lo_r <= rdy_lo_r + AFS_CNT_W'(1);
        end
    end

    sequence s_cs_fall;
        $fell(pin_s2_r[P_CS]);
    endsequence

    sequence s_lat_fall;
        $fell(pin_s2_r[P_LAT]);
    endsequence

    chk_afs_settle_delay : assert property (@(posedge core_clk) disable iff (!resetn)
        $rose(act_r) |-> rdy_lo_r >= AFS_CNT_W'(AFS_CYC))
        else $error("active rose before settle delay");

    chk_afs_drop : assert property (@(posedge core_clk) disable iff (!resetn)
        pin_s2_r[P_RDY] |=> !act_r)
        else $error("active stayed high with ready high");

    chk_fault_unpowered : assert property (@(posedge core_clk) disable iff (!resetn)
        !act_r |-> fault_oe_r)
        else $error("fault released while unpowered");

    chk_fault_follow : assert property (@(posedge core_clk) disable iff (!resetn)
        !pin_s2_r[P_FLT] |=> fault_oe_r)
        else $error("field fault not shown");

    chk_sdo_float : assert property (@(posedge core_clk) disable iff (!resetn)
        (pin_s2_r[P_CS] && pin_s2_r[P_SERIAL_OUT_ENABLE_N]) |=> !sdo_oe_r)
        else $error("serial output driven with select and enable high");

    chk_sdo_enable : assert property (@(posedge core_clk) disable iff (!resetn)
        !(pin_s2_r[P_CS] && pin_s2_r[P_SERIAL_OUT_ENABLE_N]) |=> sdo_oe_r)
        else $error("serial output enable wrong");

    chk_cs_follow : assert property (@(posedge core_clk) disable iff (!resetn)
        s_cs_fall |=> !fcs_r ##0 sdo_oe_r)
        else $error("field select did not follow host select");

    chk_latch_follow : assert property (@(posedge core_clk) disable iff (!resetn)
        s_lat_fall |=> !flat_r)
        else $error("field latch did not follow strobe");

    chk_snap_frozen : assert property (@(posedge core_clk) disable iff (!resetn)
        !(fcs_r && flat_r) |=> $stable(snap_r))
        else $error("inputs changed while latched");

    chk_sdo_first_bit : assert property (@(negedge host_serial_clock)
        disable iff (frame_clr)
        tx_first_r |=> sdo_r == (snap_act_r && $past(snap_r[DATA_W-1])))
        else $error("first serial bit wrong");

    chk_sdi_sample : assert property (@(posedge host_serial_clock)
        disable iff (frame_clr)
        1'b1 |=> rx_sh_r[0] == $past(host_serial_in))
        else $error("serial input not sampled on rising edge");
endmodule : isl_port

// ===== rtl/isl_stream_if.sv
`timescale 1ns/1ps
interface isl_stream_if #(parameter int W = 8);
    logic [W-1:0] data;
    logic         valid;
    logic         ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface : isl_stream_if

// ===== verification/isl_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Host SPI master, mode 3
// ----------------------------------------
module isl_host_model (
    // Host drives
    output logic      host_serial_clock,
    output logic      host_chip_select_n,
    output logic      host_serial_in,
    // Device answers
    input  wire logic host_serial_out,
    input  wire logic field_serial_clock,
    input  wire logic isolated_serial_in_copy
);
    localparam int HALF_NS = 32;

    // Clock idles high and stands still between frames
    initial
    begin
        host_serial_clock  = 1'b1;
        host_chip_select_n = 1'b1;
        host_serial_in     = 1'b0;
    end

    task automatic set_cs(input logic v);
        host_chip_select_n = v;
    endtask : set_cs

    task automatic frame(input logic [15:0] tx, input int nbits, input int lead_ns,
                         output logic [15:0] rx, output int err);
        logic seen;
        rx = '0;
        err = 0;
        host_chip_select_n = 1'b0;
        #(lead_ns);
        for (int i = 0; i < nbits; i++)
        begin
            host_serial_clock = 1'b0;
            host_serial_in = tx[nbits-1-i];
            #(HALF_NS);
            host_serial_clock = 1'b1;
            seen = host_serial_out;
            rx = {rx[14:0], seen};
            #2;
            if (field_serial_clock !== 1'b1 || isolated_serial_in_copy !== tx[nbits-1-i])
                err++;
            #(HALF_NS - 4);
            if (host_serial_out !== seen)
                err++;
            #2;
        end
        #(HALF_NS);
        host_chip_select_n = 1'b1;
        // Released data line shows a changed level, not the last bit
        host_serial_in = ~host_serial_in;
    endtask : frame
endmodule : isl_host_model

// ===== verification/isl_port_tb.sv
`timescale 1ns/1ps
module isl_port_tb;
    import isl_pkg::*;
    localparam int CYC_LIMIT = 12000;

    logic                core_clk;
    logic                resetn;
    logic                host_serial_clock;
    logic                host_chip_select_n;
    logic                host_serial_in;
    logic                host_latch_strobe_n;
    logic                serial_out_enable_n;
    logic                host_serial_out;
    logic                host_serial_out_oe;
    logic                host_fault_n_out;
    logic                host_fault_n_oe;
    logic                field_side_active;
    logic                field_chip_select_n;
    logic                field_serial_clock;
    logic                field_latch_n;
    logic                isolated_serial_in_copy;
    logic                field_serial_in;
    logic                field_ready_in_n;
    logic                field_fault_in_n;
    logic [DATA_W-1:0]   field_inputs;
    logic [DATA_W-1:0]   rx_data;
    logic                rx_valid;
    logic                rx_ready;
    int                  n_mismatch = 0;
    int                  cmp_count = 0;
    int                  cyc = 0;

    // ----------------------------------------
    // Clock, instances
    // ----------------------------------------
    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // standalone loop-back of the data copy
    assign field_serial_in = isolated_serial_in_copy;

    isl_host_model host (
        .host_serial_clock       (host_serial_clock),
        .host_chip_select_n      (host_chip_select_n),
        .host_serial_in          (host_serial_in),
        .host_serial_out         (host_serial_out),
        .field_serial_clock      (field_serial_clock),
        .isolated_serial_in_copy (isolated_serial_in_copy)
    );

    isl_port dut (
        .core_clk                (core_clk),
        .resetn                  (resetn),
        .host_serial_clock       (host_serial_clock),
        .host_chip_select_n      (host_chip_select_n),
        .host_serial_in          (host_serial_in),
        .host_latch_strobe_n     (host_latch_strobe_n),
        .serial_out_enable_n     (serial_out_enable_n),
        .host_serial_out         (host_serial_out),
        .host_serial_out_oe      (host_serial_out_oe),
        .host_fault_n_out        (host_fault_n_out),
        .host_fault_n_oe         (host_fault_n_oe),
        .field_side_active       (field_side_active),
        .field_chip_select_n     (field_chip_select_n),
        .field_serial_clock      (field_serial_clock),
        .field_latch_n           (field_latch_n),
        .isolated_serial_in_copy (isolated_serial_in_copy),
        .field_serial_in         (field_serial_in),
        .field_ready_in_n        (field_ready_in_n),
        .field_fault_in_n        (field_fault_in_n),
        .field_inputs            (field_inputs),
        .rx_data                 (rx_data),
        .rx_valid                (rx_valid),
        .rx_ready                (rx_ready)
    );

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : conclude

    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == CYC_LIMIT)
        begin
            n_mismatch++;
            conclude();
        end
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic waitn(input int n);
        repeat (n) @(negedge core_clk);
    endtask : waitn

    // Select held 800 ns before the first clock so the inputs freeze first
    task automatic spi_byte(input logic [7:0] tx, input logic [7:0] exp);
        logic [15:0] rx;
        int          err;
        host.frame({8'h00, tx}, 8, 800, rx, err);
        check("sdo_bits", rx[7:0], exp);
        check("link_err", 8'(err), 8'h00);
        waitn(6);
    endtask : spi_byte

    task automatic get_byte(input logic [7:0] exp);
        int n;
        n = 0;
        while (rx_valid !== 1'b1 && n < 200)
        begin
            @(negedge core_clk);
            n++;
        end
        check("rx_data", rx_data, exp);
        rx_ready = 1'b1;
        @(negedge core_clk);
        rx_ready = 1'b0;
    endtask : get_byte

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_unpowered();
        field_inputs = 8'hFF;
        spi_byte(8'h81, 8'h00);
        check("active", {7'h0, field_side_active}, 8'h00);
        check("fault_oe", {7'h0, host_fault_n_oe}, 8'h01);
        get_byte(8'h81);
    endtask : t_unpowered

    task automatic t_select();
        logic c;
        logic e;
        for (int i = 0; i < 4; i++)
        begin
            c = i[1];
            e = i[0];
            host.set_cs(c);
            serial_out_enable_n = e;
            waitn(4);
            check("sdo_oe", {7'h0, host_serial_out_oe}, {7'h0, ~(c & e)});
            check("field_cs", {7'h0, field_chip_select_n}, {7'h0, c});
        end
        serial_out_enable_n = 1'b1;
        waitn(4);
    endtask : t_select

    task automatic t_power();
        field_ready_in_n = 1'b0;
        waitn(1995);
        check("active_early", {7'h0, field_side_active}, 8'h00);
        waitn(15);
        check("active_on", {7'h0, field_side_active}, 8'h01);
        check("fault_idle", {7'h0, host_fault_n_oe}, 8'h00);
        field_fault_in_n = 1'b0;
        waitn(4);
        check("fault_on", {7'h0, host_fault_n_oe}, 8'h01);
        check("fault_low", {7'h0, host_fault_n_out}, 8'h00);
        field_fault_in_n = 1'b1;
        waitn(4);
        check("fault_off", {7'h0, host_fault_n_oe}, 8'h00);
        field_ready_in_n = 1'b1;
        waitn(4);
        check("active_off", {7'h0, field_side_active}, 8'h00);
        check("fault_down", {7'h0, host_fault_n_oe}, 8'h01);
        field_ready_in_n = 1'b0;
        waitn(2010);
        check("active_again", {7'h0, field_side_active}, 8'h01);
    endtask : t_power

    task automatic t_latch();
        field_inputs = 8'hC3;
        waitn(4);
        host_latch_strobe_n = 1'b0;
        waitn(4);
        check("latch_low", {7'h0, field_latch_n}, 8'h00);
        field_inputs = 8'h00;
        waitn(4);
        spi_byte(8'h5A, 8'hC3);
        host_latch_strobe_n = 1'b1;
        waitn(4);
        check("latch_high", {7'h0, field_latch_n}, 8'h01);
        get_byte(8'h5A);
    endtask : t_latch

    task automatic t_freeze();
        field_inputs = 8'hA5;
        waitn(4);
        fork
            spi_byte(8'h3C, 8'hA5);
            begin
                waitn(10);
                field_inputs = 8'h5A;
            end
        join
        get_byte(8'h3C);
    endtask : t_freeze

    // Stalled consumer: output, buffer and pending word hold ten; the eleventh replaces the tenth
    task automatic t_fifo();
        field_inputs = 8'h96;
        for (int i = 0; i < 11; i++)
            spi_byte(8'h10 + 8'(i), 8'h96);
        waitn(10);
        for (int i = 0; i < 9; i++)
            get_byte(8'h10 + 8'(i));
        get_byte(8'h1A);
        waitn(3);
        check("fifo_empty", {7'h0, rx_valid}, 8'h00);
    endtask : t_fifo

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        resetn = 1'b0;
        host_latch_strobe_n = 1'b1;
        serial_out_enable_n = 1'b1;
        field_ready_in_n = 1'b1;
        field_fault_in_n = 1'b1;
        field_inputs = 8'h00;
        rx_ready = 1'b0;
        waitn(16);
        check("rst_oe", {7'h0, host_serial_out_oe}, 8'h00);
        check("rst_fault", {7'h0, host_fault_n_oe}, 8'h01);
        check("rst_cs", {7'h0, field_chip_select_n}, 8'h01);
        check("rst_rxv", {7'h0, rx_valid}, 8'h00);
        resetn = 1'b1;
        waitn(4);
        t_unpowered();
        t_select();
        t_power();
        t_latch();
        t_freeze();
        t_fifo();
        conclude();
    end
endmodule : isl_port_tb
